// *** datamem_defines.svh ***
`ifndef DATAMEM_DEFINES_SVH
`define DATAMEM_DEFINES_SVH
`define SFR_STATUS_ADDR   8'hD0
`define SFR_SECOND_ADDR   8'hF0
`define SFR_ACC_ADDR      8'hE0
`define STATUS_RESET      8'h00
`define SECOND_RESET      8'h00
`define BIT_CARRY         7
`define BIT_HALF          6
`define BIT_USER0         5
`define BIT_BANK_HI       4
`define BIT_BANK_LO       3
`define BIT_OVER          2
`define BIT_USER1         1
`define BIT_PARITY        0
`define DIRECT_RAM_TOP    8'h7F
`define BIT_AREA_BASE     8'h20
`define URAM_BYTES        4608
`define URAM_TOP          16'h11FF
`define ROM_BASE          16'h1200
`define ROM_TOP           16'h41FF
`define WINDOW_BASE       16'h4000
`define WINDOW_HI         8'h40
`define UNSPEC_READ       8'hFF
`endif

// *** datamem_pkg.sv ***
package datamem_pkg;
  typedef enum logic [2:0] {
    OP_NONE, OP_ADD, OP_ADDC, OP_SUBB, OP_MUL, OP_DIV, OP_LOGIC
  } alu_op_t;
endpackage

// *** flag_if.sv ***
`timescale 1ns/1ps
interface flag_if;
  logic          valid;
  datamem_pkg::alu_op_t op;
  logic [7:0]    a;
  logic [7:0]    b;
  logic          cin;
  logic          cy;
  logic          ac;
  logic          ov;
  logic          upd_c;
  logic          upd_ac;
  logic          upd_ov;
  modport core (output valid, op, a, b, cin, input cy, ac, ov, upd_c, upd_ac, upd_ov);
  modport unit (input valid, op, a, b, cin, output cy, ac, ov, upd_c, upd_ac, upd_ov);
endinterface

// *** flag_unit.sv ***
`timescale 1ns/1ps
module flag_unit
  import datamem_pkg::*;
(
  flag_if.unit f
);
  logic [8:0]  sum;
  logic [4:0]  nib;
  logic [15:0] prod;
  logic        cin_v;

  always_comb begin
    cin_v    = (f.op == OP_ADD) ? 1'b0 : f.cin;
    sum      = 9'h000;
    nib      = 5'h00;
    prod     = 16'(f.a) * 16'(f.b);
    f.cy     = 1'b0;
    f.ac     = 1'b0;
    f.ov     = 1'b0;
    f.upd_c  = 1'b0;
    f.upd_ac = 1'b0;
    f.upd_ov = 1'b0;
    if (f.valid) begin
      unique case (f.op)
        OP_ADD, OP_ADDC: begin
          sum      = 9'(f.a) + 9'(f.b) + 9'(cin_v);
          nib      = 5'(f.a[3:0]) + 5'(f.b[3:0]) + 5'(cin_v);
          f.cy     = sum[8];
          f.ac     = nib[4];
          f.ov     = (f.a[7] == f.b[7]) && (sum[7] != f.a[7]);
          f.upd_c  = 1'b1;
          f.upd_ac = 1'b1;
          f.upd_ov = 1'b1;
        end
        OP_SUBB: begin
          sum      = 9'(f.a) - 9'(f.b) - 9'(cin_v);
          nib      = 5'(f.a[3:0]) - 5'(f.b[3:0]) - 5'(cin_v);
          f.cy     = sum[8];
          f.ac     = nib[4];
          f.ov     = (f.a[7] != f.b[7]) && (sum[7] != f.a[7]);
          f.upd_c  = 1'b1;
          f.upd_ac = 1'b1;
          f.upd_ov = 1'b1;
        end
        OP_MUL: begin
          f.ov     = (prod > 16'h00FF);
          f.upd_c  = 1'b1;
          f.upd_ov = 1'b1;
        end
        OP_DIV: begin
          f.ov     = (f.b == 8'h00);
          f.upd_c  = 1'b1;
          f.upd_ov = 1'b1;
        end
        OP_NONE, OP_LOGIC: begin
        end
      endcase
    end
  end
endmodule // flag_unit

// *** datamem_core.sv ***
`timescale 1ns/1ps
`include "datamem_defines.svh"
module datamem_core
  import datamem_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  // Internal data port
  input  wire logic        IDATA_EN,
  input  wire logic        IDATA_WR,
  input  wire logic        IDATA_INDIRECT,
  input  wire logic        IDATA_BANKREG,
  input  wire logic        IDATA_BIT,
  input  wire logic [7:0]  IDATA_ADDR,
  input  wire logic [7:0]  IDATA_WDATA,
  output logic      [7:0]  IDATA_RDATA,
  // Accumulator value from the core
  input  wire logic [7:0]  ACC_VALUE,
  // Arithmetic flag update request
  input  wire logic        ALU_VALID,
  input  alu_op_t          ALU_OP,
  input  wire logic [7:0]  ALU_A,
  input  wire logic [7:0]  ALU_B,
  // External / code space port
  input  wire logic        XMEM_EN,
  input  wire logic        XMEM_WR,
  input  wire logic        XMEM_FETCH,
  input  wire logic [15:0] XMEM_ADDR,
  input  wire logic [7:0]  XMEM_WDATA,
  output logic      [7:0]  XMEM_RDATA,
  output logic             XWIN_SEL,
  output logic      [7:0]  XWIN_ADDR,
  output logic             XWIN_WR,
  output logic      [7:0]  XWIN_WDATA,
  input  wire logic [7:0]  XWIN_RDATA,
  input  wire logic [7:0]  ROM_RDATA,
  output logic      [7:0]  STATUS_WORD,
  output logic      [7:0]  SECOND_ACC
);
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] second;
    logic [7:0] irdata;
    logic [7:0] xrdata;
    logic       win_sel;
    logic [7:0] win_addr;
    logic       win_wr;
    logic [7:0] win_wdata;
    logic       win_pend;
    logic       rom_pend;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // Arrays kept outside the struct; they carry no reset
  logic [7:0] iram [0:255];
  logic [7:0] uram [0:`URAM_BYTES-1];

  flag_if fl();
  assign fl.valid = ALU_VALID;
  assign fl.op    = ALU_OP;
  assign fl.a     = ALU_A;
  assign fl.b     = ALU_B;
  assign fl.cin   = state_reg.status[`BIT_CARRY];

  flag_unit u_flags (
    .f (fl.unit)
  );

  function automatic logic odd_parity(input logic [7:0] v);
    return ^v;
  endfunction

  // Register operand Rn lands in the selected bank
  function automatic logic [7:0] bank_addr(input logic [1:0] bank, input logic [2:0] rn);
    return {3'h0, bank, rn};
  endfunction

  // ------------------------------------------------------------
  // Internal address resolution
  // ------------------------------------------------------------
  logic [7:0] byte_addr;
  logic [2:0] bit_pos;
  logic       is_sfr;
  logic [7:0] ptr_val;
  logic [1:0] bank;

  always_comb begin
    bank    = state_reg.status[`BIT_BANK_HI:`BIT_BANK_LO];
    ptr_val = iram[bank_addr(bank, {2'b00, IDATA_ADDR[0]})];
    bit_pos = IDATA_ADDR[2:0];
    is_sfr  = 1'b0;
    if (IDATA_BANKREG) begin
      byte_addr = bank_addr(bank, IDATA_ADDR[2:0]);
    end else if (IDATA_INDIRECT) begin
      byte_addr = ptr_val;
    end else if (IDATA_BIT) begin
      if (IDATA_ADDR[7]) begin
        byte_addr = {IDATA_ADDR[7:3], 3'b000};
        is_sfr    = 1'b1;
      end else begin
        byte_addr = `BIT_AREA_BASE + {4'h0, IDATA_ADDR[6:3]};
      end
    end else begin
      byte_addr = IDATA_ADDR;
      is_sfr    = (IDATA_ADDR > `DIRECT_RAM_TOP);
    end
  end

  // Current SFR byte seen by a read or read-modify-write
  logic [7:0] sfr_cur;
  logic [7:0] cur_byte;
  logic [7:0] new_byte;
  logic       win_hit;
  logic       rom_hit;

  always_comb begin
    unique case (byte_addr)
      `SFR_STATUS_ADDR: sfr_cur = {state_reg.status[7:1], odd_parity(ACC_VALUE)};
      `SFR_SECOND_ADDR: sfr_cur = state_reg.second;
      `SFR_ACC_ADDR:    sfr_cur = ACC_VALUE;
      default:          sfr_cur = 8'h00;
    endcase
    cur_byte = is_sfr ? sfr_cur : iram[byte_addr];
    new_byte = cur_byte;
    if (IDATA_BIT) begin
      new_byte[bit_pos] = IDATA_WDATA[0];
    end else begin
      new_byte = IDATA_WDATA;
    end
    // Window decode on the high address byte; ROM decode by address range
    win_hit = (XMEM_ADDR[15:8] == `WINDOW_HI);
    rom_hit = !win_hit && (XMEM_ADDR >= `ROM_BASE) && (XMEM_ADDR <= `ROM_TOP);
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    state_next          = state_reg;
    state_next.win_sel  = 1'b0;
    state_next.win_wr   = 1'b0;
    state_next.win_pend = 1'b0;
    state_next.rom_pend = 1'b0;
    // Flags from arithmetic first; a same-cycle software write wins over them
    if (fl.upd_c) state_next.status[`BIT_CARRY] = fl.cy;
    if (fl.upd_c) state_next.status[`BIT_HALF]  = fl.upd_ac ? fl.ac : state_reg.status[`BIT_HALF];
    if (fl.upd_ov) state_next.status[`BIT_OVER] = fl.ov;
    if (IDATA_EN) begin
      if (IDATA_BIT) begin
        state_next.irdata = {7'h00, cur_byte[bit_pos]};
      end else begin
        state_next.irdata = cur_byte;
      end
      if (IDATA_WR && is_sfr) begin
        unique case (byte_addr)
          `SFR_STATUS_ADDR: state_next.status = {new_byte[7:1], 1'b0};
          `SFR_SECOND_ADDR: state_next.second = new_byte;
          default: ;
        endcase
      end
    end
    if (XMEM_EN) begin
      state_next.xrdata = (XMEM_ADDR <= `URAM_TOP) ? uram[XMEM_ADDR[12:0]] : `UNSPEC_READ;
      if (rom_hit) begin
        // Only a fetch sees ROM content; data reads stay unspecified
        state_next.rom_pend = XMEM_FETCH;
      end
      if (win_hit) begin
        state_next.win_sel   = 1'b1;
        state_next.win_addr  = XMEM_ADDR[7:0];
        state_next.win_wr    = XMEM_WR && !XMEM_FETCH;
        state_next.win_wdata = XMEM_WDATA;
        state_next.win_pend  = !XMEM_WR;
      end
    end
    // Window data arrives one cycle after the select
    if (state_reg.win_pend) state_next.xrdata = XWIN_RDATA;
    if (state_reg.rom_pend) state_next.xrdata = ROM_RDATA;
    state_next.status[`BIT_PARITY] = odd_parity(ACC_VALUE);
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg        <= '0;
      state_reg.status <= `STATUS_RESET;
      state_reg.second <= `SECOND_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // RAM writes: internal RAM never touched by direct access above 0x7F
  always_ff @(posedge SYS_CLK) begin
    if (IDATA_EN && IDATA_WR && !is_sfr) begin
      iram[byte_addr] <= new_byte;
    end
    if (XMEM_EN && XMEM_WR && !XMEM_FETCH && (XMEM_ADDR <= `URAM_TOP)) begin
      uram[XMEM_ADDR[12:0]] <= XMEM_WDATA;
    end
  end

  assign IDATA_RDATA = state_reg.irdata;
  assign XMEM_RDATA  = state_reg.xrdata;
  assign XWIN_SEL    = state_reg.win_sel;
  assign XWIN_ADDR   = state_reg.win_addr;
  assign XWIN_WR     = state_reg.win_wr;
  assign XWIN_WDATA  = state_reg.win_wdata;
  assign STATUS_WORD = state_reg.status;
  assign SECOND_ACC  = state_reg.second;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence div_zero_s;
    ALU_VALID && ALU_OP == OP_DIV && ALU_B == 8'h00 && !(IDATA_EN && IDATA_WR && is_sfr);
  endsequence

  second_reset_a: assert property (@(posedge SYS_CLK) $rose(RST_N) |-> SECOND_ACC == 8'h00)
    else $error("second register not zero after reset");
  carry_add_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    ALU_VALID && ALU_OP == OP_ADD && !IDATA_EN |=> STATUS_WORD[7] == $past(9'(ALU_A) + 9'(ALU_B)) >> 8)
    else $error("carry wrong after add");
  half_add_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    ALU_VALID && ALU_OP == OP_ADD && !IDATA_EN |=> STATUS_WORD[6] == (($past(ALU_A) & 8'h0F) + ($past(ALU_B) & 8'h0F) > 15))
    else $error("half carry wrong after add");
  user_flag_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !IDATA_EN |=> $stable({STATUS_WORD[5], STATUS_WORD[1]}))
    else $error("user flag changed without write");
  mul_over_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    ALU_VALID && ALU_OP == OP_MUL && ALU_A == 8'h10 && ALU_B == 8'h10 && !IDATA_EN |=> STATUS_WORD[2])
    else $error("multiply overflow missed");
  div_zero_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) div_zero_s |=> STATUS_WORD[2])
    else $error("divide by zero overflow missed");
  parity_acc_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    ##1 STATUS_WORD[0] == ^$past(ACC_VALUE))
    else $error("parity does not follow accumulator");
  sfr_route_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    IDATA_EN && !IDATA_INDIRECT && !IDATA_BANKREG && !IDATA_BIT && IDATA_ADDR[7] |-> is_sfr)
    else $error("direct upper access not routed to SFR");
endmodule // datamem_core

// *** window_model.sv ***
`timescale 1ns/1ps
module window_model (
  input  wire logic        clk,
  input  wire logic        sel,
  input  wire logic        wr,
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        xen,
  input  wire logic [15:0] xaddr,
  output logic      [7:0]  rdata,
  output logic      [7:0]  rom_data
);
  logic [7:0]  regs [256];
  logic [7:0]  toggle_reg = 8'h00;
  logic [15:0] xaddr_reg  = 16'h0000;
  always @(posedge clk) begin
    toggle_reg <= ~toggle_reg;
    if (xen) xaddr_reg <= xaddr;
    if (sel && wr) regs[addr] <= wdata;
  end
  // Deselected bus keeps changing so a stale sample cannot pass as a match
  assign rdata    = sel ? regs[addr] : toggle_reg;
  assign rom_data = xaddr_reg[7:0] ^ 8'h5A;
endmodule // window_model

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
  import datamem_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, id_en = 1'b0, id_wr = 1'b0, id_ind = 1'b0, id_bank = 1'b0, id_bit = 1'b0;
  logic [7:0] id_addr = 8'h00, id_wdata = 8'h00, acc = 8'h00, alu_a = 8'h00, alu_b = 8'h00, x_wdata = 8'h00;
  logic alu_valid = 1'b0, x_en = 1'b0, x_wr = 1'b0, x_fetch = 1'b0, xw_sel, xw_wr;
  alu_op_t alu_op = OP_NONE;
  logic [15:0] x_addr = 16'h0000;
  logic [7:0] id_rdata, x_rdata, xw_addr, xw_wdata, xw_rdata, rom_rdata, status, second, r, psw_m, b_m;
  int seed = 69, error_cnt = 0, cmp_count = 0, v;
  always #12.5 sys_clk = ~sys_clk;
  datamem_core dut (.SYS_CLK(sys_clk), .RST_N(rst_n), .IDATA_EN(id_en), .IDATA_WR(id_wr), .IDATA_INDIRECT(id_ind),
    .IDATA_BANKREG(id_bank), .IDATA_BIT(id_bit), .IDATA_ADDR(id_addr), .IDATA_WDATA(id_wdata), .IDATA_RDATA(id_rdata),
    .ACC_VALUE(acc), .ALU_VALID(alu_valid), .ALU_OP(alu_op), .ALU_A(alu_a), .ALU_B(alu_b), .XMEM_EN(x_en),
    .XMEM_WR(x_wr), .XMEM_FETCH(x_fetch), .XMEM_ADDR(x_addr), .XMEM_WDATA(x_wdata), .XMEM_RDATA(x_rdata),
    .XWIN_SEL(xw_sel), .XWIN_ADDR(xw_addr), .XWIN_WR(xw_wr), .XWIN_WDATA(xw_wdata), .XWIN_RDATA(xw_rdata),
    .ROM_RDATA(rom_rdata), .STATUS_WORD(status), .SECOND_ACC(second));
  window_model partner (.clk(sys_clk), .sel(xw_sel), .wr(xw_wr), .addr(xw_addr), .wdata(xw_wdata), .xen(x_en),
    .xaddr(x_addr), .rdata(xw_rdata), .rom_data(rom_rdata));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("Counts: %0d compares, %0d errors", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic logic [7:0] pexp();
    return {psw_m[7:1], ^acc};
  endfunction
  task automatic idata(input bit wr, ind, bk, bt, input logic [7:0] a, w);
    @(posedge sys_clk);
    id_en <= 1'b1; id_wr <= wr; id_ind <= ind; id_bank <= bk; id_bit <= bt; id_addr <= a; id_wdata <= w;
    @(posedge sys_clk);
    id_en <= 1'b0;
    #1 r = id_rdata;
  endtask
  task automatic xmem(input bit wr, f, input logic [15:0] a, input logic [7:0] w, input int lat);
    @(posedge sys_clk);
    x_en <= 1'b1; x_wr <= wr; x_fetch <= f; x_addr <= a; x_wdata <= w;
    @(posedge sys_clk);
    x_en <= 1'b0;
    repeat (lat - 1) @(posedge sys_clk);
    #1 r = x_rdata;
  endtask
  task automatic alu(input alu_op_t op, input int a, b);
    int c, s;
    c = (op == OP_ADD) ? 0 : psw_m[7];
    @(posedge sys_clk);
    alu_valid <= 1'b1; alu_op <= op; alu_a <= a[7:0]; alu_b <= b[7:0];
    case (op)
      OP_ADD, OP_ADDC: begin
        s = a + b + c;
        psw_m[7] = s > 255; psw_m[6] = (a % 16 + b % 16 + c) > 15; psw_m[2] = ((~(a ^ b)) & (a ^ s) & 128) != 0;
      end
      OP_SUBB: begin
        s = a - b - c;
        psw_m[7] = a < b + c; psw_m[6] = (a % 16) < (b % 16 + c); psw_m[2] = ((a ^ b) & (a ^ s) & 128) != 0;
      end
      OP_MUL: begin psw_m[7] = 1'b0; psw_m[2] = a * b > 255; end
      OP_DIV: begin psw_m[7] = 1'b0; psw_m[2] = b == 0; end
      default: ;
    endcase
    @(posedge sys_clk);
    alu_valid <= 1'b0;
    #1 chk(status, pexp());
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    $display("Error %0t: run did not finish", $time);
    final_report;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    psw_m = 8'h00;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1 chk(status, 8'h00);
    chk(second, 8'h00);
    idata(0, 0, 0, 0, 8'hF0, 8'h00); chk(r, 8'h00);
    b_m = $random(seed);
    idata(1, 0, 0, 0, 8'hF0, b_m); #1 chk(second, b_m);
    b_m[3] = ~b_m[3];
    idata(1, 0, 0, 1, 8'hF3, {7'h00, b_m[3]}); chk(second, b_m);
    $display("Test second operand done");
    // Parity bit written as 1 while the accumulator is even
    idata(1, 0, 0, 0, 8'hD0, 8'hFF); psw_m = 8'hFE; #1 chk(status, pexp());
    idata(1, 0, 0, 0, 8'hD0, 8'h22); psw_m = 8'h22;
    for (int i = 0; i < 16; i++) begin
      @(posedge sys_clk) acc <= $random(seed);
      @(posedge sys_clk) #1 chk(status, pexp());
    end
    $display("Test parity done");
    alu(OP_MUL, 16, 16); alu(OP_MUL, 15, 17); alu(OP_DIV, 9, 0); alu(OP_DIV, 9, 3);
    alu(OP_ADD, 127, 1); alu(OP_ADD, 255, 1); alu(OP_SUBB, 128, 1); alu(OP_SUBB, 0, 1);
    for (int i = 0; i < 60; i++) alu(alu_op_t'(1 + $unsigned($random(seed)) % 6), $random(seed) & 255,
      $random(seed) & 255);
    $display("Test arithmetic flags done");
    for (int bk = 0; bk < 4; bk++) begin
      psw_m = {3'b000, bk[1:0], 3'b000};
      idata(1, 0, 0, 0, 8'hD0, psw_m);
      v = $random(seed) & 255;
      idata(1, 0, 1, 0, bk * 2 + 1, v); idata(0, 0, 0, 0, bk * 10 + 1, 8'h00); chk(r, v);
      idata(1, 0, 0, 0, bk * 8, 8'h40 + bk); idata(1, 1, 0, 0, 8'h00, v);
      idata(0, 0, 0, 0, 8'h40 + bk, 8'h00); chk(r, v);
      idata(1, 0, 0, 0, bk * 8 + 1, 8'hD0); idata(1, 1, 0, 0, 8'h01, ~v);
      idata(0, 1, 0, 0, 8'h01, 8'h00); chk(r, ~v);
      idata(0, 0, 0, 0, 8'hD0, 8'h00); chk(r, pexp());
      idata(0, 0, 0, 0, 8'hE0, 8'h00); chk(r, acc);
    end
    $display("Test banks and indirect done");
    idata(1, 0, 0, 0, 8'h22, 8'h00); idata(1, 0, 0, 1, 8'h13, 8'h01);
    idata(0, 0, 0, 0, 8'h22, 8'h00); chk(r, 8'h08);
    idata(0, 0, 0, 1, 8'h13, 8'h00); chk({7'h00, r[0]}, 8'h01);
    $display("Test bit area done");
    xmem(1, 0, 16'h0000, 8'hA5, 1); xmem(1, 0, 16'h11FF, 8'h3C, 1);
    xmem(0, 0, 16'h0000, 8'h00, 1); chk(r, 8'hA5);
    xmem(0, 1, 16'h11FF, 8'h00, 1); chk(r, 8'h3C);
    xmem(1, 0, 16'h2000, 8'h11, 1); xmem(0, 0, 16'h2000, 8'h00, 2); chk(r, 8'hFF);
    xmem(0, 1, 16'h2034, 8'h00, 2); chk(r, 8'h34 ^ 8'h5A);
    xmem(1, 0, 16'h4010, 8'h6B, 1); xmem(0, 0, 16'h4010, 8'h00, 2); chk(r, 8'h6B);
    $display("Test external space done");
    final_report;
  end
endmodule // tb
